/* core/hlc_consts.vh */
// constants for the hardware loop controller: states, count sources, widths and reset values
`ifndef HLC_CONSTS_VH
`define HLC_CONSTS_VH
`define HLC_ST_IDLE 2'h0
`define HLC_ST_PUSH1 2'h1
`define HLC_ST_PUSH2 2'h2
`define HLC_ST_ARM 2'h3
`define HLC_SRC_IMM 2'h0
`define HLC_SRC_REG 2'h1
`define HLC_SRC_MEM 2'h2
`define HLC_IMM_W 19
`define HLC_LF_BIT 15
`define HLC_SP_RST 4'h0
`endif

/* core/hlc_loop_ctrl.v */
// hardware loop controller: loop start sequencing and end-of-loop handling
`timescale 1ns/1ps
`include "hlc_consts.vh"
module hlc_loop_ctrl #(
  parameter AW = 32,
  parameter DW = 32,
  parameter SPW = 4
) (
  clk_sys,
  rst_b,
  loop_start,
  count_src,
  count_imm,
  count_operand,
  end_addr_ext,
  next_fetch_pointer,
  status_in,
  fetch_valid,
  fetch_addr,
  busy,
  loop_active_flag,
  loop_end_address,
  loop_iteration_count,
  stack_pointer,
  stack_wr,
  stack_wr_ptr,
  stack_high_word,
  stack_low_word,
  stack_hi_rd,
  stack_lo_rd,
  stack_lo2_hi,
  stack_lo2_lo,
  branch_back,
  branch_target,
  loop_exit,
  restored_status
);
  input clk_sys;
  input rst_b;
  input loop_start;
  input [1:0] count_src;
  input [`HLC_IMM_W-1:0] count_imm;
  input [DW-1:0] count_operand;
  input [AW-1:0] end_addr_ext;
  input [AW-1:0] next_fetch_pointer;
  input [DW-1:0] status_in;
  input fetch_valid;
  input [AW-1:0] fetch_addr;
  input [AW-1:0] stack_hi_rd;
  input [DW-1:0] stack_lo_rd;
  input [AW-1:0] stack_lo2_hi;
  input [DW-1:0] stack_lo2_lo;
  output reg busy;
  output reg loop_active_flag;
  output reg [AW-1:0] loop_end_address;
  output reg [DW-1:0] loop_iteration_count;
  output reg [SPW-1:0] stack_pointer;
  output reg stack_wr;
  output reg [SPW-1:0] stack_wr_ptr;
  output reg [AW-1:0] stack_high_word;
  output reg [DW-1:0] stack_low_word;
  output reg branch_back;
  output reg [AW-1:0] branch_target;
  output reg loop_exit;
  output reg [DW-1:0] restored_status;

  localparam ST_IDLE = `HLC_ST_IDLE;
  localparam ST_PUSH1 = `HLC_ST_PUSH1;
  localparam ST_PUSH2 = `HLC_ST_PUSH2;
  localparam ST_ARM = `HLC_ST_ARM;
  localparam LFB = `HLC_LF_BIT;
  localparam IMMW = `HLC_IMM_W;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg busy_d;
  reg flag_d;
  reg [AW-1:0] end_addr_d;
  reg [DW-1:0] count_d;
  reg [SPW-1:0] sp_d;
  reg wr_d;
  reg [SPW-1:0] wr_ptr_d;
  reg [AW-1:0] hi_word_d;
  reg [DW-1:0] lo_word_d;
  reg back_d;
  reg [AW-1:0] target_d;
  reg exit_d;
  reg [DW-1:0] status_d;
  reg [DW-1:0] new_count;
  wire at_end;
  wire count_is_one;
  wire [DW-1:0] one_cnt;
  wire [DW-1:0] count_dec;
  wire [DW-1:0] imm_ext;
  wire [SPW-1:0] sp_one;
  wire [SPW-1:0] sp_two;
  wire [SPW-1:0] sp_inc;
  wire [SPW-1:0] sp_dec2;
  wire [DW-1:0] merged_status;
  genvar gi;

  assign one_cnt = {{(DW-1){1'b0}}, 1'b1};
  assign sp_one = {{(SPW-1){1'b0}}, 1'b1};
  assign sp_two = {{(SPW-2){1'b0}}, 2'b10};
  assign sp_inc = stack_pointer + sp_one;
  assign sp_dec2 = stack_pointer - sp_two;
  // zero is kept as is: the decrement wraps, giving 2^32 passes
  assign count_dec = loop_iteration_count - one_cnt;
  assign count_is_one = (loop_iteration_count == one_cnt);
  assign imm_ext = {{(DW-IMMW){1'b0}}, count_imm};
  // compare is done on the fetch address, ahead of execution
  assign at_end = loop_active_flag && fetch_valid && !busy &&
                  (fetch_addr == loop_end_address);

  // memory operand arrives already resolved by the address unit
  always @* begin
    case (count_src)
      `HLC_SRC_IMM: new_count = imm_ext;
      `HLC_SRC_REG: new_count = count_operand;
      `HLC_SRC_MEM: new_count = count_operand;
      default: new_count = count_operand;
    endcase
  end

  // only the loop flag comes back from the stack; other status bits stay
  generate
    for (gi = 0; gi < DW; gi = gi + 1) begin : g_status
      if (gi == LFB) begin : g_flag
        assign merged_status[gi] = stack_lo_rd[gi];
      end else begin : g_keep
        assign merged_status[gi] = status_in[gi];
      end
    end
  endgenerate

  always @* begin
    state_d = state_q;
    busy_d = busy;
    flag_d = loop_active_flag;
    end_addr_d = loop_end_address;
    count_d = loop_iteration_count;
    sp_d = stack_pointer;
    wr_d = 1'b0;
    wr_ptr_d = stack_wr_ptr;
    hi_word_d = stack_high_word;
    lo_word_d = stack_low_word;
    back_d = 1'b0;
    target_d = branch_target;
    exit_d = 1'b0;
    status_d = restored_status;
    case (state_q)
      ST_IDLE: begin
        if (loop_start) begin
          state_d = ST_PUSH1;
          busy_d = 1'b1;
          // first entry: old end address and count
          wr_d = 1'b1;
          wr_ptr_d = sp_inc;
          hi_word_d = loop_end_address;
          lo_word_d = loop_iteration_count;
          sp_d = sp_inc;
          count_d = new_count;
        end else if (at_end) begin
          if (!count_is_one) begin
            count_d = count_dec;
            back_d = 1'b1;
            // registered target: the loop top is the next fetch
            target_d = stack_hi_rd;
          end else begin
            flag_d = stack_lo_rd[LFB];
            status_d = merged_status;
            end_addr_d = stack_lo2_hi;
            count_d = stack_lo2_lo;
            sp_d = sp_dec2;
            exit_d = 1'b1;
          end
        end
      end
      ST_PUSH1: begin
        state_d = ST_PUSH2;
        wr_d = 1'b1;
        wr_ptr_d = sp_inc;
        hi_word_d = next_fetch_pointer;
        lo_word_d = status_in;
        sp_d = sp_inc;
        end_addr_d = end_addr_ext;
      end
      ST_PUSH2: begin
        state_d = ST_ARM;
        flag_d = 1'b1;
      end
      ST_ARM: begin
        // one spare cycle keeps a new loop's compare off the old pipeline
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
      default: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else begin
      busy <= busy_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      loop_active_flag <= 1'b0;
    end else begin
      loop_active_flag <= flag_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      loop_end_address <= {AW{1'b0}};
    end else begin
      loop_end_address <= end_addr_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      loop_iteration_count <= {DW{1'b0}};
    end else begin
      loop_iteration_count <= count_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stack_pointer <= `HLC_SP_RST;
    end else begin
      stack_pointer <= sp_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stack_wr <= 1'b0;
    end else begin
      stack_wr <= wr_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stack_wr_ptr <= `HLC_SP_RST;
    end else begin
      stack_wr_ptr <= wr_ptr_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stack_high_word <= {AW{1'b0}};
    end else begin
      stack_high_word <= hi_word_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stack_low_word <= {DW{1'b0}};
    end else begin
      stack_low_word <= lo_word_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      branch_back <= 1'b0;
    end else begin
      branch_back <= back_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      branch_target <= {AW{1'b0}};
    end else begin
      branch_target <= target_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      loop_exit <= 1'b0;
    end else begin
      loop_exit <= exit_d;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      restored_status <= {DW{1'b0}};
    end else begin
      restored_status <= status_d;
    end
  end
endmodule

/* verif/hlc_loop_props.sv */
// assertion checker for the hardware loop controller
`timescale 1ns/1ps
module hlc_loop_props #(parameter AW = 32, DW = 32, SPW = 4) (
  input wire clk_sys, rst_b, loop_start, busy, fetch_valid, stack_wr,
  input wire loop_active_flag, branch_back, loop_exit,
  input wire [AW-1:0] fetch_addr, next_fetch_pointer, loop_end_address,
  input wire [AW-1:0] end_addr_ext, stack_high_word, stack_hi_rd,
  input wire [AW-1:0] branch_target, stack_lo2_hi,
  input wire [DW-1:0] status_in, stack_lo_rd, loop_iteration_count,
  input wire [DW-1:0] stack_low_word, restored_status, stack_lo2_lo,
  input wire [SPW-1:0] stack_pointer
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire go = loop_start && !busy;
  wire hit = fetch_valid && !busy && loop_active_flag &&
    fetch_addr == loop_end_address;
  push_one_a: assert property (go |=> stack_wr &&
    stack_high_word == $past(loop_end_address) &&
    stack_low_word == $past(loop_iteration_count)) else $error("push one");
  push_two_a: assert property (go |-> ##2 stack_wr &&
    stack_high_word == $past(next_fetch_pointer) &&
    stack_low_word == $past(status_in) &&
    loop_end_address == $past(end_addr_ext)) else $error("push two");
  flag_set_a: assert property (go |-> ##3 loop_active_flag ##1 !busy)
    else $error("flag late");
  sp_step_a: assert property (stack_wr |->
    stack_pointer == $past(stack_pointer) + 4'h1) else $error("sp push");
  end_hit_a: assert property (hit |=> branch_back != loop_exit &&
    loop_exit == ($past(loop_iteration_count) == 1)) else $error("hit");
  loop_back_a: assert property (branch_back |->
    branch_target == $past(stack_hi_rd) &&
    loop_iteration_count == $past(loop_iteration_count) - 1)
    else $error("back");
  loop_exit_a: assert property (loop_exit |->
    stack_pointer == $past(stack_pointer) - 4'h2 &&
    loop_end_address == $past(stack_lo2_hi) &&
    loop_iteration_count == $past(stack_lo2_lo)) else $error("exit");
  status_keep_a: assert property (loop_exit |->
    restored_status == {$past(status_in[31:16]), $past(stack_lo_rd[15]),
    $past(status_in[14:0])} && loop_active_flag == restored_status[15])
    else $error("status");
  reset_flag_a: assert property (disable iff (1'b0) !rst_b |=>
    !loop_active_flag) else $error("reset");
  cover property (go);
  cover property (branch_back);
  cover property (loop_exit);
endmodule
bind hlc_loop_ctrl hlc_loop_props #(.AW(AW), .DW(DW), .SPW(SPW)) chk (.*);

/* verif/hlc_loop_ctrl_tb.sv */
// self-checking bench for the hardware loop controller
`timescale 1ns/1ps
module hlc_loop_ctrl_tb;
  reg clk_sys = 0, rst_b = 0, loop_start = 0, fetch_valid = 0;
  reg [1:0] count_src = 0;
  reg [18:0] count_imm = 0;
  reg [31:0] count_operand = 0, end_addr_ext = 0, next_fetch_pointer = 0;
  reg [31:0] status_in = 0, fetch_addr = 0, ci, co;
  wire busy, loop_active_flag, stack_wr, branch_back, loop_exit;
  wire [3:0] stack_pointer, stack_wr_ptr;
  wire [31:0] loop_end_address, loop_iteration_count, stack_high_word;
  wire [31:0] stack_low_word, branch_target, restored_status;
  reg [63:0] stk [0:15];
  wire [63:0] top = stk[stack_pointer], nxt = stk[stack_pointer - 4'h1];
  wire [31:0] stack_hi_rd = top[63:32], stack_lo_rd = top[31:0];
  wire [31:0] stack_lo2_hi = nxt[63:32], stack_lo2_lo = nxt[31:0];
  integer failures = 0, check_count = 0, seed = 9, i;
  reg [32:0] q [$];
  hlc_loop_ctrl uut (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  // stack memory sits outside the block, so the bench plays it
  always @(posedge clk_sys) begin
    if (stack_wr) stk[stack_wr_ptr] <= {stack_high_word, stack_low_word};
    if (branch_back | loop_exit) check({loop_exit, loop_exit ?
      loop_iteration_count : branch_target}, q.pop_front());
  end
  task check(input [32:0] seen, input [32:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task start(input [1:0] s, input [31:0] c, input [31:0] e, input [31:0] p);
    begin
      @(posedge clk_sys);
      loop_start <= 1;
      count_src <= s;
      count_imm <= c[18:0];
      count_operand <= c;
      @(posedge clk_sys);
      loop_start <= 0;
      end_addr_ext <= e;
      next_fetch_pointer <= p;
      // pushed status carries the live loop flag so nesting unwinds
      status_in <= ($random(seed) & 32'hFFFF7FFF) |
        {16'h0, loop_active_flag, 15'h0};
      repeat (5) @(posedge clk_sys);
    end
  endtask
  // last pass expects the restored count, earlier ones the loop top
  task run(input [31:0] a, input [31:0] p, input [31:0] n, input [31:0] r);
    for (i = 1; i <= n; i = i + 1) begin
      q.push_back(i == n ? {1'b1, r} : {1'b0, p});
      @(posedge clk_sys);
      fetch_addr <= a;
      @(posedge clk_sys);
      fetch_addr <= a - 32'h1;
      repeat (2) @(posedge clk_sys);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    for (i = 0; i < 16; i = i + 1) stk[i] = 64'h0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1;
    fetch_valid <= 1;
    co = ($random(seed) & 3) + 2;
    ci = ($random(seed) & 3) + 1;
    start(2'h0, co, 32'h100, 32'h10);
    start(2'h1, ci, 32'hF0, 32'h20);
    run(32'hF0, 32'h20, ci, co);
    run(32'h100, 32'h10, co, 32'h0);
    start(2'h2, 32'h1, 32'h200, 32'h30);
    run(32'h200, 32'h30, 32'h1, 32'h0);
    test_done;
  end
  initial begin
    #5000;
    failures = failures + 1;
    test_done;
  end
endmodule
